// File: shared/heater_current_monitor_defs.vh
/*
 * Constants for the two-channel heater current monitor: register byte
 * offsets, field positions, reset values, timing and scaling figures.
 * Assumes inclusion by bare name from each design file.
 */
`ifndef HEATER_CURRENT_MONITOR_DEFS_VH
`define HEATER_CURRENT_MONITOR_DEFS_VH

// Clock and timing
`define CT_CLK_HZ 100000000
`define CT_MS_PER_S 1000
`define CT_MEAS_MS 9'h064
`define CT_WAIT_MIN_MS 9'h01E
`define CT_WAIT_MAX_MS 9'h12C
`define CT_WAIT_RST 9'h01E

// Register byte offsets
`define CT_CFG0_ADDR 6'h00
`define CT_WAIT0_ADDR 6'h04
`define CT_CFG1_ADDR 6'h08
`define CT_WAIT1_ADDR 6'h0C
`define CT_STAT_ADDR 6'h10
`define CT_MASK_ADDR 6'h14
`define CT_ON0_ADDR 6'h18
`define CT_OFF0_ADDR 6'h1C
`define CT_ON1_ADDR 6'h20
`define CT_OFF1_ADDR 6'h24
`define CT_DISP0_ADDR 6'h28
`define CT_DISP1_ADDR 6'h2C
`define CT_MRNG0_ADDR 6'h30
`define CT_MRNG1_ADDR 6'h34

// Configuration fields
`define CT_OPTYPE_BIT 0
`define CT_OUTSEL_LSB 4
`define CT_OUTSEL_MSB 6
`define CT_TURNS_LSB 8
`define CT_TURNS_MSB 13
`define CT_PASSES_LSB 16
`define CT_PASSES_MSB 18
`define CT_OPTYPE_RST 1'b0
`define CT_OUTSEL_RST 3'h0
`define CT_OUTSEL_MAX 3'h4
`define CT_TURNS_RST 6'h08
`define CT_TURNS_MAX 6'h28
`define CT_TURNS_ZERO 6'h08
`define CT_PASSES_RST 3'h1
`define CT_PASSES_MAX 3'h6
`define CT_PASSES_ZERO 3'h1

// Status and mask fields
`define CT_ST_DONE_LSB 0
`define CT_ST_ERR_LSB 2
`define CT_STAT_RST 4'h0
`define CT_MASK_RST 4'h0

// Scaling, results in tenths of an ampere
`define CT_TURNS_UNIT 17'h00064
`define CT_TENTHS 17'h0000A
`define CT_DISP_X10 17'h0000E
`define CT_HI_DIV 17'h00010
`define CT_LO_DIV 17'h007D0

`endif

// File: hdl/ct_range.v
/*
 * Range calculator for one current input: display ceiling and the valid
 * measuring range, all in tenths of an ampere, from turns and passes.
 * Assumes settings already clamped to their legal ranges.
 */
`timescale 1ns/1ps
`include "heater_current_monitor_defs.vh"

module ct_range (
    input wire clk,
    input wire reset,
    input wire [5:0] turns,
    input wire [2:0] passes,
    output reg [15:0] disp_ceiling,
    output reg [15:0] meas_low,
    output reg [15:0] meas_high
);
    wire [5:0] turns_eff;
    wire [2:0] passes_eff;
    wire [16:0] turns_w;
    wire [16:0] passes_w;
    wire [16:0] hi_num;
    wire [16:0] disp_num;
    wire [16:0] hi_den;
    wire [16:0] lo_den;
    wire [16:0] disp_q;
    wire [16:0] hi_q;
    wire [16:0] lo_q;

    // Zero codes stand for 800 turns and one pass
    assign turns_eff = (turns == 6'h00) ? `CT_TURNS_ZERO : turns;
    assign passes_eff = (passes == 3'h0) ? `CT_PASSES_ZERO : passes;
    assign turns_w = {11'h000, turns_eff};
    assign passes_w = {14'h0000, passes_eff};
    assign hi_num = turns_w * `CT_TURNS_UNIT * `CT_TENTHS;
    assign disp_num = turns_w * `CT_TURNS_UNIT * `CT_DISP_X10;
    assign hi_den = passes_w * `CT_HI_DIV;
    assign lo_den = passes_w * `CT_LO_DIV;
    // Integer tenths keep error under 0.1 A
    assign disp_q = disp_num / hi_den;
    assign hi_q = hi_num / hi_den;
    assign lo_q = hi_num / lo_den;

    always @(posedge clk) begin
        if (reset) begin
            disp_ceiling <= 16'h0000;
            meas_low <= 16'h0000;
            meas_high <= 16'h0000;
        end else begin
            disp_ceiling <= disp_q[15:0];
            meas_low <= lo_q[15:0];
            meas_high <= hi_q[15:0];
        end
    end
endmodule // ct_range

// File: hdl/ct_channel.v
/*
 * One current channel: watches the chosen output, waits for settling,
 * measures the peak over a fixed window and keeps on and off results.
 * Assumes samples and output states come from logic on the same clock.
 */
`timescale 1ns/1ps
`include "heater_current_monitor_defs.vh"

module ct_channel #(
    parameter MS_CYCLES = 100000
) (
    input wire clk,
    input wire reset,
    input wire op_type,
    input wire [2:0] out_sel,
    input wire [8:0] wait_ms,
    input wire [4:0] outs,
    input wire [15:0] sample,
    input wire sample_valid,
    input wire [15:0] ceiling,
    output reg [15:0] on_current,
    output reg [15:0] off_current,
    output reg done,
    output reg over
);
    localparam ST_IDLE = 3'b001;
    localparam ST_WAIT = 3'b010;
    localparam ST_MEAS = 3'b100;
    localparam integer MS_LAST = MS_CYCLES - 1;

    reg [2:0] state_reg;
    reg [16:0] sub_reg;
    reg [8:0] ms_reg;
    reg [15:0] peak_reg;
    reg mon_prev_reg;
    reg mode_prev_reg;
    reg level_reg;
    wire monitored;
    wire changed;
    wire restart;
    wire tick;
    wire [15:0] peak_next;

    assign monitored = (out_sel <= `CT_OUTSEL_MAX) ? outs[out_sel] : 1'b0;
    assign changed = ~op_type & (monitored != mon_prev_reg);
    assign restart = (op_type != mode_prev_reg);
    assign tick = ({15'h0000, sub_reg} == MS_LAST);
    assign peak_next = (sample_valid && sample > peak_reg) ? sample : peak_reg;

    always @(posedge clk) begin
        if (reset) begin
            state_reg <= ST_IDLE;
            sub_reg <= 17'h00000;
            ms_reg <= 9'h000;
            peak_reg <= 16'h0000;
            mon_prev_reg <= 1'b0;
            mode_prev_reg <= 1'b0;
            level_reg <= 1'b0;
            on_current <= 16'h0000;
            off_current <= 16'h0000;
            done <= 1'b0;
            over <= 1'b0;
        end else begin
            mon_prev_reg <= monitored;
            mode_prev_reg <= op_type;
            done <= 1'b0;
            over <= sample_valid & (sample > ceiling);
            sub_reg <= tick ? 17'h00000 : sub_reg + 17'h00001;
            case (state_reg)
                ST_IDLE: begin
                    sub_reg <= 17'h00000;
                    ms_reg <= 9'h000;
                    peak_reg <= 16'h0000;
                    if (op_type) begin
                        state_reg <= ST_MEAS;
                    end else if (changed) begin
                        state_reg <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (restart) begin
                        state_reg <= ST_IDLE;
                    end else if (changed) begin
                        sub_reg <= 17'h00000;
                        ms_reg <= 9'h000;
                    end else if (tick) begin
                        if (ms_reg + 9'h001 >= wait_ms) begin
                            state_reg <= ST_MEAS;
                            ms_reg <= 9'h000;
                            peak_reg <= 16'h0000;
                            level_reg <= monitored;
                        end else begin
                            ms_reg <= ms_reg + 9'h001;
                        end
                    end
                end
                ST_MEAS: begin
                    if (restart) begin
                        state_reg <= ST_IDLE;
                    end else if (changed) begin
                        state_reg <= ST_WAIT;
                        sub_reg <= 17'h00000;
                        ms_reg <= 9'h000;
                    end else begin
                        peak_reg <= peak_next;
                        if (tick) begin
                            if (ms_reg == `CT_MEAS_MS - 9'h001) begin
                                done <= 1'b1;
                                ms_reg <= 9'h000;
                                peak_reg <= 16'h0000;
                                if (op_type || level_reg) begin
                                    on_current <= peak_next;
                                end else begin
                                    off_current <= peak_next;
                                end
                                state_reg <= op_type ? ST_MEAS : ST_IDLE;
                            end else begin
                                ms_reg <= ms_reg + 9'h001;
                            end
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
            if (op_type) begin
                off_current <= 16'h0000;
            end
        end
    end
endmodule // ct_channel

// File: hdl/heater_current_monitor.v
/*
 * Two-channel heater current monitor with an Avalon-MM register slave,
 * per-channel settings, results, ranges, alarms and an interrupt.
 * Assumes samples (tenths of an ampere) and output states arrive from
 * logic on clk; the event logic reads the current outputs directly.
 */
`timescale 1ns/1ps
`include "heater_current_monitor_defs.vh"

module heater_current_monitor #(
    parameter MS_CYCLES = `CT_CLK_HZ / `CT_MS_PER_S
) (
    input wire clk,
    input wire reset,
    input wire [5:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    input wire [3:0] byteenable,
    output reg [31:0] readdata,
    output wire waitrequest,
    input wire [1:0] ctrl_out,
    input wire [2:0] event_out,
    input wire [15:0] ct_sample0,
    input wire ct_sample_valid0,
    input wire [15:0] ct_sample1,
    input wire ct_sample_valid1,
    output wire [15:0] on_current0,
    output wire [15:0] off_current0,
    output wire [15:0] on_current1,
    output wire [15:0] off_current1,
    output reg [1:0] input_err,
    output wire irq
);
    reg ack_reg;
    reg [3:0] stat_reg;
    reg [3:0] mask_reg;
    reg [1:0] done_d_reg;
    reg [31:0] rd_word;
    reg op_type_reg [0:1];
    reg [2:0] out_sel_reg [0:1];
    reg [5:0] turns_reg [0:1];
    reg [2:0] passes_reg [0:1];
    reg [8:0] wait_reg [0:1];
    wire [31:0] be_mask;
    wire [31:0] wr_word;
    wire wr_take;
    wire rd_first;
    wire [4:0] outs;
    wire [15:0] sample [0:1];
    wire sample_valid [0:1];
    wire [15:0] on_cur [0:1];
    wire [15:0] off_cur [0:1];
    wire [15:0] ceil [0:1];
    wire [15:0] mlow [0:1];
    wire [15:0] mhigh [0:1];
    wire [1:0] done;
    wire [1:0] over;
    wire [3:0] stat_set;
    wire [3:0] stat_clr;

    // Bus handshake: one wait cycle, then the answer
    assign waitrequest = (read | write) & ~ack_reg;
    assign wr_take = write & ack_reg;
    assign rd_first = read & ~ack_reg;
    assign be_mask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                      {8{byteenable[1]}}, {8{byteenable[0]}}};
    // Unselected lanes keep their present contents
    assign wr_word = (writedata & be_mask) | (rd_word & ~be_mask);

    always @(posedge clk) begin
        if (reset) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (read | write) & ~ack_reg;
        end
    end

    assign outs = {event_out, ctrl_out};
    assign sample[0] = ct_sample0;
    assign sample[1] = ct_sample1;
    assign sample_valid[0] = ct_sample_valid0;
    assign sample_valid[1] = ct_sample_valid1;
    assign on_current0 = on_cur[0];
    assign off_current0 = off_cur[0];
    assign on_current1 = on_cur[1];
    assign off_current1 = off_cur[1];

    // Read-back word for the addressed register
    always @* begin
        rd_word = 32'h00000000;
        if (address == `CT_CFG0_ADDR) begin
            rd_word[`CT_OPTYPE_BIT] = op_type_reg[0];
            rd_word[`CT_OUTSEL_MSB:`CT_OUTSEL_LSB] = out_sel_reg[0];
            rd_word[`CT_TURNS_MSB:`CT_TURNS_LSB] = turns_reg[0];
            rd_word[`CT_PASSES_MSB:`CT_PASSES_LSB] = passes_reg[0];
        end else if (address == `CT_WAIT0_ADDR) begin
            rd_word[8:0] = wait_reg[0];
        end else if (address == `CT_CFG1_ADDR) begin
            rd_word[`CT_OPTYPE_BIT] = op_type_reg[1];
            rd_word[`CT_OUTSEL_MSB:`CT_OUTSEL_LSB] = out_sel_reg[1];
            rd_word[`CT_TURNS_MSB:`CT_TURNS_LSB] = turns_reg[1];
            rd_word[`CT_PASSES_MSB:`CT_PASSES_LSB] = passes_reg[1];
        end else if (address == `CT_WAIT1_ADDR) begin
            rd_word[8:0] = wait_reg[1];
        end else if (address == `CT_STAT_ADDR) begin
            rd_word[3:0] = stat_reg;
        end else if (address == `CT_MASK_ADDR) begin
            rd_word[3:0] = mask_reg;
        end else if (address == `CT_ON0_ADDR) begin
            rd_word[15:0] = on_cur[0];
        end else if (address == `CT_OFF0_ADDR) begin
            rd_word[15:0] = off_cur[0];
        end else if (address == `CT_ON1_ADDR) begin
            rd_word[15:0] = on_cur[1];
        end else if (address == `CT_OFF1_ADDR) begin
            rd_word[15:0] = off_cur[1];
        end else if (address == `CT_DISP0_ADDR) begin
            rd_word[15:0] = ceil[0];
        end else if (address == `CT_DISP1_ADDR) begin
            rd_word[15:0] = ceil[1];
        end else if (address == `CT_MRNG0_ADDR) begin
            rd_word = {mhigh[0], mlow[0]};
        end else if (address == `CT_MRNG1_ADDR) begin
            rd_word = {mhigh[1], mlow[1]};
        end
    end

    // Read data captured in the wait cycle, stands at the answer edge
    always @(posedge clk) begin
        if (reset) begin
            readdata <= 32'h00000000;
        end else if (rd_first) begin
            readdata <= rd_word;
        end
    end

    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : chan
            wire [5:0] cfg_addr;
            wire [5:0] wait_addr;
            wire [5:0] turns_in;
            wire [2:0] passes_in;
            wire [2:0] sel_in;
            wire [8:0] wait_in;

            assign cfg_addr = (i == 0) ? `CT_CFG0_ADDR : `CT_CFG1_ADDR;
            assign wait_addr = (i == 0) ? `CT_WAIT0_ADDR : `CT_WAIT1_ADDR;
            assign turns_in = wr_word[`CT_TURNS_MSB:`CT_TURNS_LSB];
            assign passes_in = wr_word[`CT_PASSES_MSB:`CT_PASSES_LSB];
            assign sel_in = wr_word[`CT_OUTSEL_MSB:`CT_OUTSEL_LSB];
            assign wait_in = wr_word[8:0];

            // Per-channel settings, out-of-range writes clamped
            always @(posedge clk) begin
                if (reset) begin
                    op_type_reg[i] <= `CT_OPTYPE_RST;
                    out_sel_reg[i] <= `CT_OUTSEL_RST;
                    turns_reg[i] <= `CT_TURNS_RST;
                    passes_reg[i] <= `CT_PASSES_RST;
                    wait_reg[i] <= `CT_WAIT_RST;
                end else if (wr_take && address == cfg_addr) begin
                    op_type_reg[i] <= wr_word[`CT_OPTYPE_BIT];
                    if (sel_in > `CT_OUTSEL_MAX) begin
                        out_sel_reg[i] <= `CT_OUTSEL_MAX;
                    end else begin
                        out_sel_reg[i] <= sel_in;
                    end
                    if (turns_in > `CT_TURNS_MAX) begin
                        turns_reg[i] <= `CT_TURNS_MAX;
                    end else begin
                        turns_reg[i] <= turns_in;
                    end
                    if (passes_in > `CT_PASSES_MAX) begin
                        passes_reg[i] <= `CT_PASSES_MAX;
                    end else begin
                        passes_reg[i] <= passes_in;
                    end
                end else if (wr_take && address == wait_addr) begin
                    if (wait_in < `CT_WAIT_MIN_MS) begin
                        wait_reg[i] <= `CT_WAIT_MIN_MS;
                    end else if (wait_in > `CT_WAIT_MAX_MS) begin
                        wait_reg[i] <= `CT_WAIT_MAX_MS;
                    end else begin
                        wait_reg[i] <= wait_in;
                    end
                end
            end

            ct_range range_u (
                .clk(clk),
                .reset(reset),
                .turns(turns_reg[i]),
                .passes(passes_reg[i]),
                .disp_ceiling(ceil[i]),
                .meas_low(mlow[i]),
                .meas_high(mhigh[i])
            );

            ct_channel #(
                .MS_CYCLES(MS_CYCLES)
            ) chan_u (
                .clk(clk),
                .reset(reset),
                .op_type(op_type_reg[i]),
                .out_sel(out_sel_reg[i]),
                .wait_ms(wait_reg[i]),
                .outs(outs),
                .sample(sample[i]),
                .sample_valid(sample_valid[i]),
                .ceiling(ceil[i]),
                .on_current(on_cur[i]),
                .off_current(off_cur[i]),
                .done(done[i]),
                .over(over[i])
            );

            // Alarm holds until a window finishes with on and off results both at or below the ceiling
            always @(posedge clk) begin
                if (reset) begin
                    input_err[i] <= 1'b0;
                    done_d_reg[i] <= 1'b0;
                end else begin
                    done_d_reg[i] <= done[i];
                    if (over[i]) begin
                        input_err[i] <= 1'b1;
                    end else if (done_d_reg[i] && on_cur[i] <= ceil[i]
                                 && off_cur[i] <= ceil[i]) begin
                        input_err[i] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Sticky events; a new event wins over a same-cycle clear
    assign stat_set = {over, done};
    assign stat_clr = (wr_take && address == `CT_STAT_ADDR) ?
                      (writedata[3:0] & be_mask[3:0]) : 4'h0;

    always @(posedge clk) begin
        if (reset) begin
            stat_reg <= `CT_STAT_RST;
            mask_reg <= `CT_MASK_RST;
        end else begin
            stat_reg <= (stat_reg & ~stat_clr) | stat_set;
            if (wr_take && address == `CT_MASK_ADDR) begin
                mask_reg <= wr_word[3:0];
            end
        end
    end

    assign irq = |(stat_reg & mask_reg);
endmodule // heater_current_monitor

// File: bench/ct_model.sv
/* Current transformer stand-in: a sample strobe every fourth clock.
   Assumes the monitor's clock; data between strobes is scrambled. */
`timescale 1ns/1ps
module ct_model (
    input wire clk,
    input wire reset,
    input wire on,
    input wire [15:0] on_level,
    input wire [15:0] off_level,
    output logic [15:0] sample,
    output logic sample_valid
);
    logic [1:0] phase_reg;
    always @(posedge clk) begin
        if (reset) begin
            phase_reg <= 2'h0;
            sample <= 16'h0;
            sample_valid <= 1'b0;
        end else begin
            phase_reg <= phase_reg + 2'h1;
            sample_valid <= (phase_reg == 2'h3);
            sample <= (phase_reg == 2'h3) ?
                (on ? on_level : off_level) : ~sample;
        end
    end
endmodule // ct_model

// File: bench/heater_current_monitor_sva.sv
/* Port assertions for the heater current monitor.
   Assumes channel 0 keeps its default range, ceiling 70.0 A. */
`timescale 1ns/1ps
module hcm_checker (
    input wire clk,
    input wire reset,
    input wire [5:0] address,
    input wire read,
    input wire write,
    input wire [31:0] readdata,
    input wire waitrequest,
    input wire [15:0] ct_sample0,
    input wire ct_sample_valid0,
    input wire [15:0] on_current0,
    input wire [15:0] off_current0,
    input wire [1:0] input_err,
    input wire irq
);
    localparam int CEIL0 = 700;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wait_first_a: assert property ((read || write) && !$past(read || write)
        |-> waitrequest) else $error("No wait on a new request");
    ack_next_a: assert property ((read || write) && waitrequest
        |=> !waitrequest) else $error("Request not taken in one wait");
    idle_nowait_a: assert property (!(read || write) |-> !waitrequest)
        else $error("Wait raised while idle");
    rd_hold_a: assert property (!(read && waitrequest) |=> $stable(readdata))
        else $error("Read data moved outside a read");
    unmapped_zero_a: assert property (read && !waitrequest
        && address == 6'h38 |-> readdata == 32'h0)
        else $error("Unmapped read not zero");
    reset_clear_a: assert property ($fell(reset) |-> on_current0 == 16'h0
        && off_current0 == 16'h0 && input_err == 2'h0 && !irq)
        else $error("Outputs not cleared by reset");
    err_raise_a: assert property (
        ct_sample_valid0 && ct_sample0 > CEIL0 |-> ##[1:2] input_err[0])
        else $error("Over-ceiling sample raised no alarm");
    err_cause_a: assert property ($rose(input_err[0]) |->
        ($past(ct_sample_valid0) && $past(ct_sample0) > CEIL0) ||
        ($past(ct_sample_valid0, 2) && $past(ct_sample0, 2) > CEIL0))
        else $error("Alarm without an over-ceiling sample");
    write_c: cover property (write && !waitrequest);
    read_c: cover property (read && !waitrequest);
    err_c: cover property ($rose(input_err[0]));
    irq_c: cover property ($rose(irq));
endmodule // hcm_checker

bind heater_current_monitor hcm_checker u_hcm_checker (.clk(clk),
    .reset(reset), .address(address), .read(read), .write(write),
    .readdata(readdata), .waitrequest(waitrequest), .ct_sample0(ct_sample0),
    .ct_sample_valid0(ct_sample_valid0), .on_current0(on_current0),
    .off_current0(off_current0), .input_err(input_err), .irq(irq));

// File: bench/heater_current_monitor_tb.sv
/* Testbench for the heater current monitor; reads checked from a queue.
   Assumes a 10-cycle millisecond so windows stay short. */
`timescale 1ns/1ps
module heater_current_monitor_tb;
    logic clk = 0, reset = 1, read = 0, write = 0;
    logic [5:0] address = 0, t;
    logic [2:0] p, sel0 = 0;
    logic [31:0] writedata = 0, seed = 32'hA0551B16;
    logic [4:0] outs = 0;
    logic [15:0] lv [4] = '{16'h0, 16'h0, 16'h0, 16'h0};
    logic [31:0] q [$];
    wire [15:0] s0, s1, oc0, fc0, oc1, fc1;
    wire v0, v1, waitrequest, irq;
    wire [31:0] readdata;
    wire [1:0] input_err;
    integer err_total = 0, checked = 0, i, k;
    initial begin
        forever #5 clk = ~clk;
    end
    heater_current_monitor #(.MS_CYCLES(10)) u_heater_current_monitor (
        .clk(clk), .reset(reset), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(4'hF),
        .readdata(readdata), .waitrequest(waitrequest),
        .ctrl_out(outs[1:0]), .event_out(outs[4:2]), .ct_sample0(s0),
        .ct_sample_valid0(v0), .ct_sample1(s1), .ct_sample_valid1(v1),
        .on_current0(oc0), .off_current0(fc0), .on_current1(oc1),
        .off_current1(fc1),
        .input_err(input_err), .irq(irq));
    ct_model u_ct_model0 (.clk(clk), .reset(reset), .on(outs[sel0]),
        .on_level(lv[0]), .off_level(lv[1]), .sample(s0), .sample_valid(v0));
    ct_model u_ct_model1 (.clk(clk), .reset(reset), .on(outs[0]),
        .on_level(lv[2]), .off_level(lv[3]), .sample(s1), .sample_valid(v1));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("Error at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wrap_up;
        begin
            $display("Mismatches %0d, checks %0d", err_total, checked);
            if (err_total == 0 && checked > 0) begin
                $display("SIMULATION PASSED");
            end else begin
                $display("SIMULATION FAILED");
            end
            $finish;
        end
    endtask
    task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        integer n;
        begin
            read <= ~wr;
            write <= wr;
            address <= a;
            writedata <= d;
            n = 0;
            @(posedge clk);
            while (waitrequest !== 1'b0) begin
                n = n + 1;
                if (n > 20) begin
                    err_total = err_total + 1;
                    wrap_up;
                end
                @(posedge clk);
            end
            read <= 1'b0;
            write <= 1'b0;
            @(posedge clk);
        end
    endtask
    task rd(input logic [5:0] a, input logic [31:0] e);
        begin
            q.push_back(e);
            bus(1'b0, a, 32'h0);
        end
    endtask
    function [31:0] cfg(input op, input [2:0] s, input [5:0] tn,
        input [2:0] ps);
        cfg = {13'h0, ps, 2'h0, tn, 1'b0, s, 3'h0, op};
    endfunction
    function [31:0] disp(input [5:0] tn, input [2:0] ps);
        integer n, m;
        begin
            n = (tn == 0 ? 8 : tn) * 100;
            m = (ps == 0 ? 1 : ps);
            disp = n * 14 / (16 * m);
        end
    endfunction
    function [31:0] mrng(input [5:0] tn, input [2:0] ps);
        integer n, m;
        begin
            n = (tn == 0 ? 8 : tn) * 1000;
            m = (ps == 0 ? 1 : ps);
            mrng = ((n / (16 * m)) << 16) | (n / (2000 * m));
        end
    endfunction
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    always @(posedge clk) begin
        if (read === 1'b1 && waitrequest === 1'b0) begin
            if (q.size() > 0) begin
                check(readdata, q.pop_front());
            end else begin
                err_total = err_total + 1;
                $display("Error at %0t: stray read %h", $time, readdata);
            end
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        rd(6'h00, cfg(1'b0, 3'h0, 6'h08, 3'h1));
        rd(6'h04, 32'h1E);
        rd(6'h28, disp(6'h08, 3'h1));
        rd(6'h30, mrng(6'h08, 3'h1));
        bus(1'b1, 6'h28, 32'h0);
        rd(6'h28, disp(6'h08, 3'h1));
        rd(6'h38, 32'h0);
        for (i = 0; i < 6; i = i + 1) begin
            seed = lfsr(seed);
            t = (i == 0) ? 6'h0 : (i == 1) ? 6'h28 : 6'(1 + seed[15:0] % 40);
            p = (i == 0) ? 3'h0 : (i == 1) ? 3'h6 : 3'(1 + seed[31:16] % 6);
            bus(1'b1, 6'h08, cfg(1'b0, 3'h0, t, p));
            repeat (2) @(posedge clk);
            rd(6'h2C, disp(t, p));
            rd(6'h34, mrng(t, p));
        end
        for (k = 0; k < 5; k = k + 1) begin
            lv[0] <= 16'(100 + k);
            sel0 <= 3'(k);
            bus(1'b1, 6'h00, cfg(1'b0, 3'(k), 6'h08, 3'h1));
            outs <= 5'(1 << k);
            repeat (1500) @(posedge clk);
            rd(6'h18, 32'(100 + k));
            check({16'h0, oc0}, 32'(100 + k));
            outs <= 5'h0;
        end
        lv[1] <= 16'h0037;
        repeat (1500) @(posedge clk);
        rd(6'h1C, 32'h37);
        check({16'h0, fc0}, 32'h37);
        rd(6'h18, 32'h68);
        bus(1'b1, 6'h10, 32'hF);
        bus(1'b1, 6'h14, 32'h1);
        bus(1'b1, 6'h04, 32'h2D);
        outs <= 5'h10;
        repeat (1440) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        repeat (25) @(posedge clk);
        check({31'h0, irq}, 32'h1);
        bus(1'b1, 6'h10, 32'h1);
        check({31'h0, irq}, 32'h0);
        bus(1'b1, 6'h08, cfg(1'b1, 3'h0, 6'h08, 3'h1));
        lv[3] <= 16'h007B;
        repeat (2100) @(posedge clk);
        rd(6'h20, 32'h7B);
        rd(6'h24, 32'h0);
        check({oc1, fc1}, 32'h007B0000);
        check({30'h0, input_err}, 32'h0);
        bus(1'b1, 6'h14, 32'h4);
        lv[0] <= 16'h0320;
        repeat (20) @(posedge clk);
        check({30'h0, input_err}, 32'h1);
        check({31'h0, irq}, 32'h1);
        wrap_up;
    end
endmodule // heater_current_monitor_tb
